// ---- hw/atl_xlate.v ----
// address translation: unified and instruction tables, register port
// assumes core requests are synchronous and single-cycle pulses
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "atl_map.vh"
module atl_xlate #(
  parameter UN = 64,
  parameter IN = 4
) (
  // clock and reset
  input wire ref_clk_i,
  input wire resetn_i,
  input wire manual_reset_i,
  // register port
  input wire [4:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_we_i,
  input wire reg_re_i,
  output reg [31:0] reg_rdata_o,
  // core mode
  input wire user_mode_i,
  // data access
  input wire d_req_i,
  input wire d_write_i,
  input wire [31:0] d_vaddr_i,
  output reg d_done_o,
  output reg d_miss_o,
  output reg d_prot_o,
  output reg d_multi_o,
  output reg [28:0] d_paddr_o,
  output reg d_cache_o,
  output reg d_wt_o,
  output reg d_dirty_o,
  output reg [2:0] d_sa_o,
  output reg d_tc_o,
  // instruction fetch
  input wire i_req_i,
  input wire [31:0] i_vaddr_i,
  output wire i_busy_o,
  output reg i_done_o,
  output reg i_exc_o,
  output reg i_reset_req_o,
  output reg [28:0] i_paddr_o,
  output reg i_cache_o,
  output reg [2:0] i_sa_o,
  output reg i_tc_o
);
  localparam ST_IDLE = `ATL_ST_IDLE;
  localparam ST_REFILL = `ATL_ST_REFILL;

  // page match using only the index bits of the entry size
  function match;
    input [21:0] ent;
    input [1:0] sz;
    input [21:0] va;
    reg [21:0] m;
    begin
      case (sz)
        2'h0: m = 22'h3FFFFF;
        2'h1: m = 22'h3FFFFC;
        2'h2: m = 22'h3FFFC0;
        default: m = 22'h3FFC00;
      endcase
      match = ((ent ^ va) & m) == 22'h000000;
    end
  endfunction

  // physical address from page index and offset
  function [28:0] xlate;
    input [18:0] physical_page_index;
    input [1:0] sz;
    input [31:0] va;
    begin
      case (sz)
        2'h0: xlate = {physical_page_index, va[9:0]};
        2'h1: xlate = {physical_page_index[18:2], va[11:0]};
        2'h2: xlate = {physical_page_index[18:6], va[15:0]};
        default: xlate = {physical_page_index[18:10], va[19:0]};
      endcase
    end
  endfunction

  // tag check of one entry
  function tag_ok;
    input sh;
    input [7:0] tag;
    input [7:0] cur;
    input sv;
    input um;
    begin
      tag_ok = sh | (sv & ~um) | (tag == cur);
    end
  endfunction

  // software state
  reg sv;
  reg [5:0] replace_counter;
  reg [1:0] iro;
  reg [21:0] page_entry_high_vpn;
  reg [7:0] cur_tag;
  reg [18:0] page_entry_low_ppn;
  reg [8:0] page_entry_low_flags;
  reg [3:0] page_entry_assist;
  reg [11:0] exc_code;
  reg [31:0] fault_addr;
  // unified table
  reg [21:0] u_vpn [0:UN-1];
  reg [7:0] u_tag [0:UN-1];
  reg [18:0] u_ppn [0:UN-1];
  reg [1:0] u_sz [0:UN-1];
  reg [1:0] u_pr [0:UN-1];
  reg [2:0] u_sa [0:UN-1];
  reg [UN-1:0] u_v, u_sh, u_c, u_d, u_wt, u_tc;
  // instruction table
  reg [21:0] i_vpn [0:IN-1];
  reg [7:0] i_tag [0:IN-1];
  reg [18:0] i_ppn [0:IN-1];
  reg [1:0] i_sz [0:IN-1];
  reg [2:0] i_sa [0:IN-1];
  reg [IN-1:0] i_v, i_sh, i_c, i_pr, i_tc;
  // fetch sequencing
  reg [1:0] state;
  reg [31:0] i_va;
  reg i_um;

  assign i_busy_o = (state != ST_IDLE);

  // unified search, for data or refill
  reg [31:0] u_va;
  reg u_um;
  reg u_hit, u_mul;
  reg [5:0] u_idx;
  integer k;
  always @* begin
    u_va = (state == ST_REFILL) ? i_va : d_vaddr_i;
    u_um = (state == ST_REFILL) ? i_um : user_mode_i;
    u_hit = 1'b0;
    u_mul = 1'b0;
    u_idx = 6'h00;
    for (k = 0; k < UN; k = k + 1) begin
      if (u_v[k] && match(u_vpn[k], u_sz[k], u_va[31:10]) &&
          tag_ok(u_sh[k], u_tag[k], cur_tag, sv, u_um)) begin
        u_mul = u_mul | u_hit;
        if (!u_hit) begin
          u_idx = k[5:0];
        end
        u_hit = 1'b1;
      end
    end
  end

  // instruction search
  reg f_hit, f_mul;
  reg [1:0] f_idx;
  reg [31:0] f_va;
  reg f_um;
  integer j;
  always @* begin
    f_va = (state == ST_REFILL) ? i_va : i_vaddr_i;
    f_um = (state == ST_REFILL) ? i_um : user_mode_i;
    f_hit = 1'b0;
    f_mul = 1'b0;
    f_idx = 2'h0;
    for (j = 0; j < IN; j = j + 1) begin
      if (i_v[j] && match(i_vpn[j], i_sz[j], f_va[31:10]) &&
          tag_ok(i_sh[j], i_tag[j], cur_tag, sv, f_um)) begin
        f_mul = f_mul | f_hit;
        if (!f_hit) begin
          f_idx = j[1:0];
        end
        f_hit = 1'b1;
      end
    end
  end

  wire u_load = reg_we_i && (reg_addr_i == `ATL_OFS_LOAD);
  wire d_go = d_req_i && (state == ST_IDLE);
  wire i_go = i_req_i && (state == ST_IDLE);
  wire [1:0] upr = u_pr[u_idx];

  // valid bits: cleared by power-on reset, kept by manual reset; a load writes the V flag
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      u_v <= {UN{1'b0}};
      i_v <= {IN{1'b0}};
    end else begin
      if (u_load) begin
        u_v[replace_counter] <= page_entry_low_flags[`ATL_PAGE_ENTRY_LOW_V];
      end
      if (state == ST_REFILL && u_hit) begin
        i_v[iro] <= 1'b1;
      end
    end
  end

  // table contents and dirty marking
  always @(posedge ref_clk_i) begin
    if (u_load) begin
      u_vpn[replace_counter] <= page_entry_high_vpn;
      u_tag[replace_counter] <= cur_tag;
      u_ppn[replace_counter] <= page_entry_low_ppn;
      u_sz[replace_counter] <= {page_entry_low_flags[`ATL_PAGE_ENTRY_LOW_SZ1], page_entry_low_flags[`ATL_PAGE_ENTRY_LOW_SZ0]};
      u_pr[replace_counter] <= page_entry_low_flags[`ATL_PAGE_ENTRY_LOW_PR];
      u_sh[replace_counter] <= page_entry_low_flags[`ATL_PAGE_ENTRY_LOW_SH];
      u_c[replace_counter] <= page_entry_low_flags[`ATL_PAGE_ENTRY_LOW_C];
      u_d[replace_counter] <= page_entry_low_flags[`ATL_PAGE_ENTRY_LOW_D];
      u_wt[replace_counter] <= page_entry_low_flags[`ATL_PAGE_ENTRY_LOW_WT];
      u_sa[replace_counter] <= page_entry_assist[`ATL_PAGE_ENTRY_ASSIST_SA];
      u_tc[replace_counter] <= page_entry_assist[`ATL_PAGE_ENTRY_ASSIST_TC];
    end else if (d_go && d_write_i && u_hit && !u_mul &&
        (!u_um || upr[1]) && upr[0]) begin
      u_d[u_idx] <= 1'b1;
    end
    if (state == ST_REFILL && u_hit) begin
      i_vpn[iro] <= u_vpn[u_idx];
      i_tag[iro] <= u_tag[u_idx];
      i_ppn[iro] <= u_ppn[u_idx];
      i_sz[iro] <= u_sz[u_idx];
      i_sh[iro] <= u_sh[u_idx];
      i_c[iro] <= u_c[u_idx];
      i_pr[iro] <= upr[1];
      i_sa[iro] <= u_sa[u_idx];
      i_tc[iro] <= u_tc[u_idx];
    end
  end

  // registers, data answer and fetch sequencer
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sv <= 1'b0;
      replace_counter <= 6'h00;
      iro <= 2'h0;
      page_entry_high_vpn <= 22'h000000;
      cur_tag <= 8'h00;
      page_entry_low_ppn <= 19'h00000;
      page_entry_low_flags <= 9'h000;
      page_entry_assist <= 4'h0;
      exc_code <= 12'h000;
      fault_addr <= 32'h00000000;
      reg_rdata_o <= 32'h00000000;
      state <= ST_IDLE;
      i_va <= 32'h00000000;
      i_um <= 1'b0;
      d_done_o <= 1'b0;
      d_miss_o <= 1'b0;
      d_prot_o <= 1'b0;
      d_multi_o <= 1'b0;
      d_paddr_o <= 29'h00000000;
      d_cache_o <= 1'b0;
      d_wt_o <= 1'b0;
      d_dirty_o <= 1'b0;
      d_sa_o <= 3'h0;
      d_tc_o <= 1'b0;
      i_done_o <= 1'b0;
      i_exc_o <= 1'b0;
      i_reset_req_o <= 1'b0;
      i_paddr_o <= 29'h00000000;
      i_cache_o <= 1'b0;
      i_sa_o <= 3'h0;
      i_tc_o <= 1'b0;
    end else if (manual_reset_i) begin
      state <= ST_IDLE;
      replace_counter <= 6'h00;
      iro <= 2'h0;
      d_done_o <= 1'b0;
      i_done_o <= 1'b0;
      i_exc_o <= 1'b0;
      i_reset_req_o <= 1'b0;
    end else begin
      d_done_o <= d_go;
      i_done_o <= 1'b0;
      i_exc_o <= 1'b0;
      i_reset_req_o <= 1'b0;
      reg_rdata_o <= 32'h00000000;
      if (reg_re_i) begin
        case (reg_addr_i)
          `ATL_OFS_CTRL: reg_rdata_o <= {16'h0000, replace_counter, iro, 7'h00, sv};
          `ATL_OFS_PAGE_ENTRY_HIGH: reg_rdata_o <= {page_entry_high_vpn, 2'h0, cur_tag};
          `ATL_OFS_PAGE_ENTRY_LOW: reg_rdata_o <= {3'h0, page_entry_low_ppn, 1'b0, page_entry_low_flags};
          `ATL_OFS_PAGE_ENTRY_ASSIST: reg_rdata_o <= {28'h0000000, page_entry_assist};
          `ATL_OFS_CODE: reg_rdata_o <= {20'h00000, exc_code};
          `ATL_OFS_FADR: reg_rdata_o <= fault_addr;
          default: reg_rdata_o <= 32'h00000000;
        endcase
      end
      if (reg_we_i) begin
        case (reg_addr_i)
          `ATL_OFS_CTRL: begin
            sv <= reg_wdata_i[`ATL_CTRL_SV];
            iro <= reg_wdata_i[`ATL_CTRL_IRO];
            replace_counter <= reg_wdata_i[`ATL_CTRL_URC];
          end
          `ATL_OFS_PAGE_ENTRY_HIGH: begin
            page_entry_high_vpn <= reg_wdata_i[31:10];
            cur_tag <= reg_wdata_i[7:0];
          end
          `ATL_OFS_PAGE_ENTRY_LOW: begin
            page_entry_low_ppn <= reg_wdata_i[28:10];
            page_entry_low_flags <= reg_wdata_i[8:0];
          end
          `ATL_OFS_PAGE_ENTRY_ASSIST: page_entry_assist <= reg_wdata_i[3:0];
          `ATL_OFS_LOAD: replace_counter <= replace_counter + 6'h01;
          default: ;
        endcase
      end
      if (d_go) begin
        d_miss_o <= ~u_hit;
        d_multi_o <= u_mul;
        d_prot_o <= u_hit & ((user_mode_i & ~upr[1]) |
                             (d_write_i & ~upr[0]));
        d_paddr_o <= xlate(u_ppn[u_idx], u_sz[u_idx], d_vaddr_i);
        d_cache_o <= u_c[u_idx];
        d_wt_o <= u_wt[u_idx];
        d_dirty_o <= u_d[u_idx] | (d_write_i & u_hit);
        d_sa_o <= u_sa[u_idx];
        d_tc_o <= u_tc[u_idx];
      end
      case (state)
        ST_IDLE: begin
          if (i_go) begin
            i_va <= i_vaddr_i;
            i_um <= user_mode_i;
            if (f_mul) begin
              fault_addr <= i_vaddr_i;
              exc_code <= `ATL_CODE_IMULTI;
              i_exc_o <= 1'b1;
              i_reset_req_o <= 1'b1;
              i_done_o <= 1'b1;
            end else if (f_hit) begin
              i_done_o <= 1'b1;
              i_paddr_o <= xlate(i_ppn[f_idx], i_sz[f_idx], i_vaddr_i);
              i_cache_o <= i_c[f_idx];
              i_sa_o <= i_sa[f_idx];
              i_tc_o <= i_tc[f_idx];
              if (user_mode_i && !i_pr[f_idx]) begin
                fault_addr <= i_vaddr_i;
                page_entry_high_vpn <= i_vaddr_i[31:10];
                exc_code <= `ATL_CODE_IPROT;
                i_exc_o <= 1'b1;
              end
            end else begin
              state <= ST_REFILL;
            end
          end
        end
        ST_REFILL: begin
          if (u_hit) begin
            iro <= iro + 2'h1;
            state <= ST_IDLE;
            i_done_o <= 1'b1;
            i_paddr_o <= xlate(u_ppn[u_idx], u_sz[u_idx], i_va);
            i_cache_o <= u_c[u_idx];
            i_sa_o <= u_sa[u_idx];
            i_tc_o <= u_tc[u_idx];
            if (i_um && !upr[1]) begin
              fault_addr <= i_va;
              page_entry_high_vpn <= i_va[31:10];
              exc_code <= `ATL_CODE_IPROT;
              i_exc_o <= 1'b1;
            end
          end else begin
            state <= ST_IDLE;
            fault_addr <= i_va;
            page_entry_high_vpn <= i_va[31:10];
            exc_code <= `ATL_CODE_IMISS;
            i_exc_o <= 1'b1;
            i_done_o <= 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // atl_xlate

// ---- hw/atl_map.vh ----
// constants for the address translation tables
// assumes a core clock of 20 MHz and a plain register port
// What this block does
// - mode bit selects single or multiple space
// - current process tag held in page_entry_high
// - 64-entry associative unified table
// - compared page index depends on size
// - size code selects 1k,4k,64k,1M pages
// - valid cleared by power-on, kept by manual
// - physical index bits used by page size
// - protection code gives read/write rights
// - dirty flag marks written pages
// - write-through flag picks cache write policy
// - space attribute passed for card pages
// - timing select picks area 5 or 6
// - 4-entry instruction table without dirty
// - instruction protection is upper code bit
// - matched entry drives cache attributes, faults
// - instruction miss refills from unified table
// - load copies entry regs into counter slot
// - instruction multi-hit records, code, reset
`ifndef ATL_MAP_VH
`define ATL_MAP_VH
`define ATL_OFS_CTRL 5'h00
`define ATL_OFS_PAGE_ENTRY_HIGH 5'h04
`define ATL_OFS_PAGE_ENTRY_LOW 5'h08
`define ATL_OFS_PAGE_ENTRY_ASSIST 5'h0C
`define ATL_OFS_LOAD 5'h10
`define ATL_OFS_CODE 5'h14
`define ATL_OFS_FADR 5'h18
`define ATL_CTRL_SV 0
`define ATL_CTRL_IRO 9:8
`define ATL_CTRL_URC 15:10
`define ATL_PAGE_ENTRY_LOW_V 8
`define ATL_PAGE_ENTRY_LOW_SZ1 7
`define ATL_PAGE_ENTRY_LOW_PR 6:5
`define ATL_PAGE_ENTRY_LOW_SZ0 4
`define ATL_PAGE_ENTRY_LOW_C 3
`define ATL_PAGE_ENTRY_LOW_D 2
`define ATL_PAGE_ENTRY_LOW_SH 1
`define ATL_PAGE_ENTRY_LOW_WT 0
`define ATL_PAGE_ENTRY_ASSIST_SA 2:0
`define ATL_PAGE_ENTRY_ASSIST_TC 3
`define ATL_CODE_IMISS 12'h040
`define ATL_CODE_IPROT 12'h0A0
`define ATL_CODE_IMULTI 12'h140
`define ATL_ST_IDLE 2'h1
`define ATL_ST_REFILL 2'h2
`endif

// ---- bench/atl_xlate_properties.sv ----
// checker on the ports of the translation block
// assumes one core clock and an active-low power-on reset
`timescale 1ns/10ps
module atl_xlate_props (
  // watched ports
  input wire ref_clk_i,
  input wire resetn_i,
  input wire reg_re_i,
  input wire [31:0] reg_rdata_o,
  input wire d_req_i,
  input wire [31:0] d_vaddr_i,
  input wire d_done_o,
  input wire d_miss_o,
  input wire d_multi_o,
  input wire [28:0] d_paddr_o,
  input wire i_req_i,
  input wire i_busy_o,
  input wire i_done_o,
  input wire i_exc_o,
  input wire i_reset_req_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  chk_rdata_idle: assert property (!$past(reg_re_i) |-> reg_rdata_o == 0)
    else $error("read data outside its slot");
  chk_data_answer: assert property (d_req_i && !i_busy_o |=> d_done_o)
    else $error("data request not answered");
  chk_done_cause: assert property (d_done_o |-> $past(d_req_i))
    else $error("data done without request");
  chk_offset_pass: assert property (
    d_done_o && !d_miss_o && !d_multi_o |->
    d_paddr_o[9:0] == $past(d_vaddr_i[9:0]))
    else $error("page offset altered");
  chk_fetch_answer: assert property (
    i_req_i && !i_busy_o |-> ##[1:2] i_done_o)
    else $error("fetch not answered");
  chk_refill_end: assert property ($fell(i_busy_o) |-> i_done_o)
    else $error("refill ended without done");
  chk_refill_len: assert property (i_busy_o |=> !i_busy_o)
    else $error("refill longer than one cycle");
  chk_multi_reset: assert property (
    i_reset_req_o |-> i_exc_o && i_done_o)
    else $error("reset request without fault");
  chk_exc_done: assert property (i_exc_o |-> i_done_o)
    else $error("fetch fault without done");
  cover property (d_done_o && d_miss_o);
  cover property (i_busy_o);
  cover property (i_reset_req_o);
endmodule // atl_xlate_props
bind atl_xlate atl_xlate_props chk (.ref_clk_i, .resetn_i, .reg_re_i,
  .reg_rdata_o, .d_req_i, .d_vaddr_i, .d_done_o, .d_miss_o, .d_multi_o,
  .d_paddr_o, .i_req_i, .i_busy_o, .i_done_o, .i_exc_o, .i_reset_req_o);

// ---- bench/atl_core_model.sv ----
// core model issuing data and fetch translation requests
// assumes each call starts just after a rising clock edge
`timescale 1ns/10ps
module atl_core_model (
  // clock
  input wire clk_i,
  // requests
  output reg d_req_o,
  output reg i_req_o,
  output reg wr_o,
  output reg um_o,
  output reg [31:0] va_o
);
  initial {d_req_o, i_req_o, wr_o, um_o, va_o} = 0;
  // one-cycle request; address scrambled once taken
  task req(input f, input [31:0] va, input w, input u);
    begin
      d_req_o <= !f;
      i_req_o <= f;
      va_o <= va;
      wr_o <= w;
      um_o <= u;
      @(posedge clk_i);
      d_req_o <= 1'b0;
      i_req_o <= 1'b0;
      va_o <= ~va;
    end
  endtask
endmodule // atl_core_model

// ---- bench/atl_xlate_bench.sv ----
// bench for the translation block with a model of both tables
// assumes the core model drives requests, the bench the registers
`timescale 1ns/10ps
module atl_xlate_bench;
  reg ref_clk_i = 0, resetn_i = 0, manual_reset_i = 0;
  reg reg_we_i = 0, reg_re_i = 0;
  reg [4:0] reg_addr_i = 0;
  reg [31:0] reg_wdata_i = 0;
  wire user_mode_i, d_req_i, d_write_i, i_req_i, d_done_o, d_miss_o;
  wire d_prot_o, d_multi_o, d_cache_o, d_wt_o, d_dirty_o, d_tc_o;
  wire i_busy_o, i_done_o, i_exc_o, i_reset_req_o, i_cache_o, i_tc_o;
  wire [31:0] reg_rdata_o, d_vaddr_i, i_vaddr_i;
  wire [28:0] d_paddr_o, i_paddr_o;
  wire [2:0] d_sa_o, i_sa_o;
  int error_cnt = 0;
  int checks = 0;
  int replace_counter, iro, k, p;
  logic [67:0] u [64];
  logic [67:0] it [4];
  logic sv;
  logic [7:0] tg;
  logic [31:0] a, l;
  always #25 ref_clk_i = ~ref_clk_i;
  assign i_vaddr_i = d_vaddr_i;
  atl_core_model core (.clk_i(ref_clk_i), .d_req_o(d_req_i),
    .i_req_o(i_req_i), .wr_o(d_write_i), .um_o(user_mode_i),
    .va_o(d_vaddr_i));
  atl_xlate #(.UN(64), .IN(4)) dut (.*);
  function automatic int sft(input [31:0] x);
    sft = 10 + (x[7] ? (x[4] ? 10 : 6) : (x[4] ? 2 : 0));
  endfunction
  function automatic bit hit(input [67:0] e, input [31:0] v, input m);
    hit = e[12] && (e[67:36] >> sft(e[35:4])) == (v >> sft(e[35:4]))
      && (e[5] || (sv && !m) || e[43:36] == tg);
  endfunction
  function automatic [28:0] pa(input [31:0] x, input [31:0] v);
    pa = 29'((x & ~((32'h1 << sft(x)) - 1)) | (v & ((32'h1 << sft(x)) - 1)));
  endfunction
  function automatic [31:0] pt(input [1:0] z, input [1:0] r, input s);
    pt = {3'h0, 19'($urandom), 2'b01, z[1], r, z[0], 1'($urandom), 1'b0,
      s, 1'($urandom)};
  endfunction
  function automatic [31:0] ctl();
    ctl = {16'h0, 6'(replace_counter), 2'(iro), 7'h0, sv};
  endfunction
  task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    begin
      checks++;
      if (e !== g) begin
        error_cnt++;
        $display("wrong value %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task wr(input [4:0] ad, input [31:0] d);
    begin
      reg_we_i <= 1;
      reg_addr_i <= ad;
      reg_wdata_i <= d;
      @(posedge ref_clk_i);
      reg_we_i <= 0;
      @(posedge ref_clk_i);
    end
  endtask
  task rd(input [4:0] ad, input [31:0] e);
    begin
      reg_re_i <= 1;
      reg_addr_i <= ad;
      @(posedge ref_clk_i);
      reg_re_i <= 0;
      @(negedge ref_clk_i);
      cmp("reg_rdata", e, reg_rdata_o);
      @(posedge ref_clk_i);
    end
  endtask
  task ld(input [31:0] h, input [31:0] lo, input [3:0] x);
    begin
      wr(5'h04, h);
      wr(5'h08, lo);
      wr(5'h0C, {28'h0, x});
      wr(5'h10, 0);
      tg = h[7:0];
      u[replace_counter] = {h, lo, x};
      replace_counter = (replace_counter + 1) % 64;
    end
  endtask
  task rst;
    begin
      resetn_i <= 0;
      repeat (10) @(posedge ref_clk_i);
      resetn_i <= 1;
      @(posedge ref_clk_i);
      {replace_counter, iro, sv, tg} = 0;
      foreach (u[j]) u[j] = 0;
      foreach (it[j]) it[j] = 0;
    end
  endtask
  task dchk(input [31:0] v, input w, input m);
    int n, x;
    logic [67:0] e;
    logic f;
    begin
      n = 0;
      x = 0;
      for (int j = 0; j < 64; j++) if (hit(u[j], v, m)) begin
        n++;
        x = j;
      end
      e = u[x];
      f = (m && !e[10]) || (w && !e[9]);
      core.req(0, v, w, m);
      @(negedge ref_clk_i);
      cmp("d_done", 1, d_done_o);
      cmp("d_miss", n == 0, d_miss_o);
      cmp("d_multi", n > 1, d_multi_o);
      if (n == 1) begin
        cmp("d_prot", f, d_prot_o);
        cmp("d_paddr", pa(e[35:4], v), d_paddr_o);
        cmp("d_attr", {e[7], e[4], e[3:0]},
          {d_cache_o, d_wt_o, d_tc_o, d_sa_o});
        if (!w) cmp("d_dirty", e[6], d_dirty_o);
        if (w && !f) u[x][6] = 1;
      end
      @(posedge ref_clk_i);
    end
  endtask
  task fchk(input [31:0] v, input m);
    int n, j;
    logic [67:0] e;
    logic [11:0] c;
    begin
      {n, c, e} = 0;
      for (j = 0; j < 4; j++) if (hit(it[j], v, m)) begin
        n++;
        e = it[j];
      end
      j = 1;
      if (n == 0) begin
        j = 2;
        for (int q = 63; q >= 0; q--) if (hit(u[q], v, m)) e = u[q];
        if (e[12]) begin
          it[iro] = e;
          iro = (iro + 1) % 4;
        end
        else c = 12'h040;
      end
      if (n > 1) c = 12'h140;
      else if (c == 0 && m && !e[10]) c = 12'h0A0;
      core.req(1, v, 0, m);
      if (j == 2) begin
        @(negedge ref_clk_i);
        cmp("i_busy", 1, i_busy_o);
        @(posedge ref_clk_i);
      end
      @(negedge ref_clk_i);
      cmp("i_done", 1, i_done_o);
      cmp("i_exc", c != 0, i_exc_o);
      cmp("i_reset_req", n > 1, i_reset_req_o);
      if (c == 0) cmp("i_paddr", pa(e[35:4], v), i_paddr_o);
      if (c == 0) cmp("i_attr", {e[7], e[3:0]},
        {i_cache_o, i_tc_o, i_sa_o});
      @(posedge ref_clk_i);
      if (c != 0) begin
        rd(5'h14, c);
        rd(5'h18, v);
      end
    end
  endtask
  task tally_and_finish;
    begin
      if (error_cnt == 0 && checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (8000) @(posedge ref_clk_i);
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(45734));
    rst;
    rd(5'h00, 0);
    rd(5'h1C, 0);
    for (k = 0; k < 64; k++) ld((k << 24) | 32'($urandom % 256),
      pt(k[1:0], 2'b11, 1), 4'($urandom));
    for (k = 0; k < 64; k++) begin
      a = k << 24;
      l = u[k][35:4];
      dchk(a | ($urandom % (1 << sft(l))), 0, 0);
      dchk(a | (1 << sft(l)), 0, 0);
    end
    rd(5'h00, ctl());
    for (p = 0; p < 16; p++) begin
      a = 32'h40000000 + (p << 20);
      ld(a, pt(2'b11, p[1:0], 1), 0);
      dchk(a, p[3], p[2]);
      dchk(a, 0, 0);
    end
    a = 32'h60000000;
    ld(a | 8'h5A, pt(2'b11, 2'b11, 0), 0);
    for (p = 0; p < 8; p++) begin
      sv = p[0];
      tg = {7'h2D, p[2]};
      wr(5'h00, ctl());
      wr(5'h04, a | tg);
      dchk(a, 0, p[1]);
    end
    rd(5'h04, a | tg);
    fchk(32'h20000010, 0);
    fchk(32'h20000020, 0);
    fchk(32'h7F000000, 0);
    fchk(32'h40000000, 1);
    a = 32'h78000000;
    ld(a, pt(2'b01, 2'b11, 1), 0);
    fchk(a, 0);
    ld(a, pt(2'b11, 2'b11, 1), 0);
    fchk(a | 32'h80000, 0);
    fchk(a | 4, 0);
    dchk(a, 0, 0);
    manual_reset_i <= 1;
    @(posedge ref_clk_i);
    manual_reset_i <= 0;
    @(posedge ref_clk_i);
    {replace_counter, iro} = 0;
    rd(5'h00, ctl());
    dchk(32'h20000010, 0, 0);
    rst;
    dchk(32'h20000010, 0, 0);
    tally_and_finish;
  end
endmodule // atl_xlate_bench
